// File: hw/phy_rgmii_fld_config_regs.sv
// configuration register bank for fast link drop and the mac interface
//
// Notes on behaviour
// RL1 - flag energy loss below three-bit floor, default one
// RL2 - strapped fast drop starts floor at two
// RL3 - software should keep floor at one
// RL4 - test flag powers up from receive-control strap
// RL5 - software must clear test flag if strapped
// RL6 - mirror bit enables port mirroring, strap default
// RL7 - interface enable bit, package dependent default
// RL8 - receive buffer midlevel field, resets to two
// RL9 - transmit buffer midlevel field, resets to two
// RL10 - transmit clock shift select, default aligned
// RL11 - receive clock shift select, default aligned
// RL12 - bypass async buffer when set, default off
// RL13 - reserved interface bits ignore writes, read zero
// RL14 - energy loss drops link only if source enabled
// RL15 - midlevels set fill where buffer reading begins
`timescale 1ns/10ps
`default_nettype none

module phy_rgmii_fld_config_regs (
  input wire logic aclk,
  input wire logic aresetn,
  // axi4-lite slave
  input wire logic [phy_cfg_pkg::ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [phy_cfg_pkg::DATA_W-1:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [phy_cfg_pkg::ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [phy_cfg_pkg::DATA_W-1:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // straps, sampled once after reset release
  input wire logic strap_fast_link_drop,
  input wire logic [2:0] strap_rx_ctrl_mode,
  input wire logic strap_mirror,
  input wire logic strap_interface_enable,
  input wire logic package_small,
  // datapath status
  input wire logic [phy_cfg_pkg::ACC_W-1:0] energy_accumulator,
  input wire logic [1:0] rx_buffer_fill,
  input wire logic [1:0] tx_buffer_fill,
  // configuration outputs
  output logic energy_lost,
  output logic fast_link_drop,
  output logic internal_test_flag,
  output logic mirror_enable,
  output logic interface_enable,
  output logic [1:0] rx_buffer_midlevel,
  output logic [1:0] tx_buffer_midlevel,
  output logic tx_clock_shift,
  output logic rx_clock_shift,
  output logic async_buffer_bypass,
  output logic rx_read_start,
  output logic tx_read_start
);

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  logic [15:0] thr_q;
  logic test_flag_q;
  logic mirror_q;
  logic tm_spare_q;
  logic if_en_q;
  logic [1:0] rx_mid_q;
  logic [1:0] tx_mid_q;
  logic tx_shift_q;
  logic rx_shift_q;
  logic bypass_q;
  logic [4:0] src_q;
  logic drop_seen_q;
  logic straps_pending_q;
  logic aw_held_q;
  logic [7:0] aw_idx_q;
  logic w_held_q;
  logic [15:0] wdata_q;
  logic [1:0] wstrb_q;
  logic bvalid_q;
  logic [1:0] bresp_q;
  logic rvalid_q;
  logic [31:0] rdata_q;
  logic [1:0] rresp_q;

  // ----------------------------------------------------------------
  // write decode
  // ----------------------------------------------------------------
  // a write commits once both address and data are held and no response is pending
  wire do_write = aw_held_q & w_held_q & ~bvalid_q;
  wire wr_thr = do_write & (aw_idx_q == phy_cfg_pkg::IDX_FAST_DROP_ENERGY_THRESHOLD);
  wire wr_tm = do_write & (aw_idx_q == phy_cfg_pkg::IDX_TEST_AND_MIRROR_CONFIG);
  wire wr_ctl = do_write & (aw_idx_q == phy_cfg_pkg::IDX_MAC_INTERFACE_CONTROL);
  wire wr_ctl2 = do_write & (aw_idx_q == phy_cfg_pkg::IDX_MAC_INTERFACE_CONTROL_TWO);
  wire wr_drop = do_write & (aw_idx_q == phy_cfg_pkg::IDX_DROP_CONTROL);
  wire wr_hit = wr_thr | wr_tm | wr_ctl | wr_ctl2 | wr_drop;

  // byte lane merge: only lanes 0 and 1 hold register bits
  wire [15:0] lane_mask = {{8{wstrb_q[1]}}, {8{wstrb_q[0]}}};
  wire [15:0] thr_new = (thr_q & ~(lane_mask & phy_cfg_pkg::THR_RW_MASK))
                      | (wdata_q & lane_mask & phy_cfg_pkg::THR_RW_MASK);
  wire lo_we = wstrb_q[0];
  wire hi_we = wstrb_q[1];

  // ----------------------------------------------------------------
  // strap derived power-up values
  // ----------------------------------------------------------------
  // modes 3 and 4 are the only normal ones; anything else raises the flag
  wire strap_test_flag = ~((strap_rx_ctrl_mode == phy_cfg_pkg::STRAP_MODE_NORMAL_A)
                         | (strap_rx_ctrl_mode == phy_cfg_pkg::STRAP_MODE_NORMAL_B)); // RL4
  wire strap_if_en = package_small | strap_interface_enable; // RL7
  wire [2:0] strap_floor = strap_fast_link_drop ? phy_cfg_pkg::FLOOR_LEVEL_STRAPPED
                                                : phy_cfg_pkg::FLOOR_LEVEL_DEFAULT; // RL2

  // ----------------------------------------------------------------
  // threshold register
  // ----------------------------------------------------------------
  // strap load wins over a write; the bus cannot complete one that early anyway
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      thr_q <= phy_cfg_pkg::THR_RESET; // RL1
    end else if (straps_pending_q) begin
      thr_q[2:0] <= strap_floor; // RL2
    end else if (wr_thr) begin
      thr_q <= thr_new;
    end
  end

  // ----------------------------------------------------------------
  // test and mirror register
  // ----------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      test_flag_q <= 1'b0;
      mirror_q <= 1'b0;
      tm_spare_q <= 1'b0;
    end else if (straps_pending_q) begin
      test_flag_q <= strap_test_flag; // RL4
      mirror_q <= strap_mirror; // RL6
    end else if (wr_tm) begin
      if (lo_we) begin
        test_flag_q <= wdata_q[phy_cfg_pkg::TEST_FLAG_BIT]; // RL5
        mirror_q <= wdata_q[phy_cfg_pkg::MIRROR_BIT]; // RL6
      end
      if (hi_we) begin
        tm_spare_q <= wdata_q[phy_cfg_pkg::TM_SPARE_BIT];
      end
    end
  end

  // ----------------------------------------------------------------
  // interface control register
  // ----------------------------------------------------------------
  // bits 15:8 and 2 are never stored, so writes to them vanish
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      if_en_q <= 1'b0;
      rx_mid_q <= phy_cfg_pkg::MIDLEVEL_RESET; // RL8
      tx_mid_q <= phy_cfg_pkg::MIDLEVEL_RESET; // RL9
      tx_shift_q <= 1'b0; // RL10
      rx_shift_q <= 1'b0; // RL11
    end else if (straps_pending_q) begin
      if_en_q <= strap_if_en; // RL7
    end else if (wr_ctl && lo_we) begin
      if_en_q <= wdata_q[phy_cfg_pkg::IF_EN_BIT]; // RL7
      rx_mid_q <= wdata_q[phy_cfg_pkg::RX_MID_LSB +: 2]; // RL8
      tx_mid_q <= wdata_q[phy_cfg_pkg::TX_MID_LSB +: 2]; // RL9
      tx_shift_q <= wdata_q[phy_cfg_pkg::TX_SHIFT_BIT]; // RL10
      rx_shift_q <= wdata_q[phy_cfg_pkg::RX_SHIFT_BIT]; // RL11
    end
  end

  // ----------------------------------------------------------------
  // second interface control and drop control
  // ----------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bypass_q <= 1'b0; // RL12
      src_q <= phy_cfg_pkg::SRC_RESET;
    end else begin
      if (wr_ctl2 && lo_we) begin
        bypass_q <= wdata_q[phy_cfg_pkg::BYPASS_BIT]; // RL12
      end
      if (wr_drop && lo_we) begin
        src_q <= wdata_q[4:0]; // RL14
      end
    end
  end

  // sticky drop record; a new drop in the clearing cycle is kept
  wire drop_clear = wr_drop & hi_we & wdata_q[phy_cfg_pkg::DROP_SEEN_BIT];
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      drop_seen_q <= 1'b0;
    end else if (fast_link_drop) begin
      drop_seen_q <= 1'b1;
    end else if (drop_clear) begin
      drop_seen_q <= 1'b0;
    end
  end

  // straps are caught on the first edge after release, not inside reset
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      straps_pending_q <= 1'b1;
    end else begin
      straps_pending_q <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // comparators
  // ----------------------------------------------------------------
  logic energy_below;
  logic rx_fill_below;
  logic tx_fill_below;

  level_compare #(.W(phy_cfg_pkg::ACC_W)) u_energy_cmp (
    .level(energy_accumulator),
    .limit({5'h00, thr_q[2:0]}),
    .below(energy_below)
  );

  level_compare #(.W(2)) u_rx_fill_cmp (
    .level(rx_buffer_fill),
    .limit(rx_mid_q),
    .below(rx_fill_below)
  );

  level_compare #(.W(2)) u_tx_fill_cmp (
    .level(tx_buffer_fill),
    .limit(tx_mid_q),
    .below(tx_fill_below)
  );

  // ----------------------------------------------------------------
  // datapath controls
  // ----------------------------------------------------------------
  assign energy_lost = energy_below; // RL1
  assign fast_link_drop = energy_below & src_q[phy_cfg_pkg::SRC_ENERGY_BIT]; // RL14
  // with the buffer bypassed there is nothing to wait for; with the interface off neither buffer starts reading
  assign rx_read_start = if_en_q & (bypass_q | ~rx_fill_below); // RL15
  assign tx_read_start = if_en_q & (bypass_q | ~tx_fill_below); // RL15
  assign internal_test_flag = test_flag_q;
  assign mirror_enable = mirror_q;
  assign interface_enable = if_en_q;
  assign rx_buffer_midlevel = rx_mid_q;
  assign tx_buffer_midlevel = tx_mid_q;
  assign tx_clock_shift = tx_shift_q;
  assign rx_clock_shift = rx_shift_q;
  assign async_buffer_bypass = bypass_q;

  // ----------------------------------------------------------------
  // read decode
  // ----------------------------------------------------------------
  wire [7:0] ar_idx = s_axi_araddr[phy_cfg_pkg::ADDR_W-1:2];
  wire [15:0] tm_word = phy_cfg_pkg::TM_FIXED
                      | {7'h00, tm_spare_q, test_flag_q, 6'h00, mirror_q};
  wire [15:0] ctl_word = {8'h00, if_en_q, rx_mid_q, tx_mid_q, 1'b0,
                          tx_shift_q, rx_shift_q}; // RL13
  wire [15:0] ctl2_word = {11'h000, bypass_q, 4'h0};
  wire [15:0] drop_word = {6'h00, drop_seen_q, energy_below, 3'h0, src_q};
  wire rd_thr = (ar_idx == phy_cfg_pkg::IDX_FAST_DROP_ENERGY_THRESHOLD);
  wire rd_tm = (ar_idx == phy_cfg_pkg::IDX_TEST_AND_MIRROR_CONFIG);
  wire rd_ctl = (ar_idx == phy_cfg_pkg::IDX_MAC_INTERFACE_CONTROL);
  wire rd_ctl2 = (ar_idx == phy_cfg_pkg::IDX_MAC_INTERFACE_CONTROL_TWO);
  wire rd_drop = (ar_idx == phy_cfg_pkg::IDX_DROP_CONTROL);
  wire rd_hit = rd_thr | rd_tm | rd_ctl | rd_ctl2 | rd_drop;
  wire [15:0] rd_word = rd_thr ? thr_q :
                        rd_tm ? tm_word :
                        rd_ctl ? ctl_word :
                        rd_ctl2 ? ctl2_word :
                        rd_drop ? drop_word : 16'h0000;

  // ----------------------------------------------------------------
  // axi write channels
  // ----------------------------------------------------------------
  assign s_axi_awready = ~aw_held_q & ~bvalid_q;
  assign s_axi_wready = ~w_held_q & ~bvalid_q;
  assign s_axi_bvalid = bvalid_q;
  assign s_axi_bresp = bresp_q;

  // address and data are taken independently, in either order
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held_q <= 1'b0;
      aw_idx_q <= 8'h00;
    end else if (s_axi_awvalid && s_axi_awready) begin
      aw_held_q <= 1'b1;
      aw_idx_q <= s_axi_awaddr[phy_cfg_pkg::ADDR_W-1:2];
    end else if (do_write) begin
      aw_held_q <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      w_held_q <= 1'b0;
      wdata_q <= 16'h0000;
      wstrb_q <= 2'h0;
    end else if (s_axi_wvalid && s_axi_wready) begin
      w_held_q <= 1'b1;
      wdata_q <= s_axi_wdata[15:0];
      wstrb_q <= s_axi_wstrb[1:0];
    end else if (do_write) begin
      w_held_q <= 1'b0;
    end
  end

  // unmapped addresses still complete, with a slave error
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bvalid_q <= 1'b0;
      bresp_q <= phy_cfg_pkg::RESP_OKAY;
    end else if (do_write) begin
      bvalid_q <= 1'b1;
      bresp_q <= wr_hit ? phy_cfg_pkg::RESP_OKAY : phy_cfg_pkg::RESP_SLVERR;
    end else if (s_axi_bready) begin
      bvalid_q <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // axi read channels
  // ----------------------------------------------------------------
  assign s_axi_arready = ~rvalid_q;
  assign s_axi_rvalid = rvalid_q;
  assign s_axi_rdata = rdata_q;
  assign s_axi_rresp = rresp_q;

  // data is captured at the address edge, so it is a snapshot of that cycle
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid_q <= 1'b0;
      rdata_q <= 32'h0000_0000;
      rresp_q <= phy_cfg_pkg::RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      rvalid_q <= 1'b1;
      rdata_q <= {16'h0000, rd_word};
      rresp_q <= rd_hit ? phy_cfg_pkg::RESP_OKAY : phy_cfg_pkg::RESP_SLVERR;
    end else if (s_axi_rready) begin
      rvalid_q <= 1'b0;
    end
  end

endmodule

`default_nettype wire

// File: common/phy_cfg_pkg.sv
// shared constants of the phy configuration register bank
package phy_cfg_pkg;

  // ----------------------------------------------------------------
  // bus geometry
  // ----------------------------------------------------------------
  localparam int ADDR_W = 10;
  localparam int DATA_W = 32;
  localparam int ACC_W = 8;

  // ----------------------------------------------------------------
  // register indices; byte address is four times the index
  // ----------------------------------------------------------------
  localparam logic [7:0] IDX_FAST_DROP_ENERGY_THRESHOLD = 8'h2e;
  localparam logic [7:0] IDX_TEST_AND_MIRROR_CONFIG = 8'h31;
  localparam logic [7:0] IDX_MAC_INTERFACE_CONTROL = 8'h32;
  localparam logic [7:0] IDX_MAC_INTERFACE_CONTROL_TWO = 8'h33;
  localparam logic [7:0] IDX_DROP_CONTROL = 8'h30;

  // ----------------------------------------------------------------
  // threshold register layout and reset values
  // ----------------------------------------------------------------
  localparam logic [15:0] THR_RW_MASK = 16'h0777;
  localparam logic [15:0] THR_RESET = 16'h0221;
  localparam logic [2:0] FLOOR_LEVEL_DEFAULT = 3'h1;
  localparam logic [2:0] FLOOR_LEVEL_STRAPPED = 3'h2;
  localparam int FLOOR_LSB = 0;

  // ----------------------------------------------------------------
  // test and mirror register layout
  // ----------------------------------------------------------------
  localparam int TEST_FLAG_BIT = 7;
  localparam int MIRROR_BIT = 0;
  localparam int TM_SPARE_BIT = 8;
  localparam logic [15:0] TM_FIXED = 16'h0010;
  localparam logic [2:0] STRAP_MODE_NORMAL_A = 3'h3;
  localparam logic [2:0] STRAP_MODE_NORMAL_B = 3'h4;

  // ----------------------------------------------------------------
  // interface control layouts and reset values
  // ----------------------------------------------------------------
  localparam int IF_EN_BIT = 7;
  localparam int RX_MID_LSB = 5;
  localparam int TX_MID_LSB = 3;
  localparam int TX_SHIFT_BIT = 1;
  localparam int RX_SHIFT_BIT = 0;
  localparam logic [1:0] MIDLEVEL_RESET = 2'h2;
  localparam int BYPASS_BIT = 4;

  // ----------------------------------------------------------------
  // drop control register layout
  // ----------------------------------------------------------------
  localparam int SRC_ENERGY_BIT = 0;
  localparam int ENERGY_LOW_BIT = 8;
  localparam int DROP_SEEN_BIT = 9;
  localparam logic [4:0] SRC_RESET = 5'h00;

  // ----------------------------------------------------------------
  // bus responses
  // ----------------------------------------------------------------
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage

// File: hw/level_compare.sv
// unsigned level comparator used for energy floor and buffer start levels
`timescale 1ns/10ps
`default_nettype none

module level_compare #(
  parameter int W = 8
) (
  input wire logic [W-1:0] level,
  input wire logic [W-1:0] limit,
  output logic below
);

  // ----------------------------------------------------------------
  // compare
  // ----------------------------------------------------------------
  // strictly below: a level equal to the limit is not a loss
  assign below = (level < limit);

endmodule

`default_nettype wire

// File: testbench/phy_cfg_monitor.sv
// checker for the phy configuration register bank ports
`timescale 1ns/10ps
`default_nettype none
module phy_cfg_monitor (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic strap_fast_link_drop,
  input wire logic [2:0] strap_rx_ctrl_mode,
  input wire logic strap_mirror,
  input wire logic strap_interface_enable,
  input wire logic package_small,
  input wire logic [7:0] energy_accumulator,
  input wire logic [1:0] rx_buffer_fill,
  input wire logic [1:0] tx_buffer_fill,
  input wire logic energy_lost,
  input wire logic fast_link_drop,
  input wire logic internal_test_flag,
  input wire logic mirror_enable,
  input wire logic interface_enable,
  input wire logic [1:0] rx_buffer_midlevel,
  input wire logic [1:0] tx_buffer_midlevel,
  input wire logic tx_clock_shift,
  input wire logic rx_clock_shift,
  input wire logic async_buffer_bypass,
  input wire logic rx_read_start,
  input wire logic tx_read_start
);
  // ----------------------------------------------------------------
  // assertions, all on the one bus clock
  // ----------------------------------------------------------------
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  a_drop_gate: assert property (fast_link_drop |-> energy_lost)
    else $error("link drop without energy loss");
  a_energy_high: assert property (energy_accumulator >= 8'h07 |-> !energy_lost)
    else $error("energy loss above any floor");
  // the floor is checked at 1 only, where strapped 2 and default 1 differ
  a_floor_strap: assert property ($rose(aresetn) ##1 (energy_accumulator == 8'h01)
    |-> energy_lost == $past(strap_fast_link_drop)) else $error("floor strap default wrong");
  a_test_strap: assert property ($rose(aresetn) |=> internal_test_flag ==
    !($past(strap_rx_ctrl_mode) inside {3'h3, 3'h4})) else $error("test flag strap wrong");
  a_mirror_enable: assert property ($rose(aresetn) |=> mirror_enable == $past(strap_mirror)
    && interface_enable == ($past(package_small) | $past(strap_interface_enable)))
    else $error("mirror or enable strap wrong");
  a_reset_fields: assert property ($rose(aresetn) |-> rx_buffer_midlevel == 2'h2
    && tx_buffer_midlevel == 2'h2 && !tx_clock_shift && !rx_clock_shift && !async_buffer_bypass)
    else $error("interface fields not at reset values");
  a_off_idle: assert property (!interface_enable |-> !rx_read_start && !tx_read_start)
    else $error("buffer read while interface off");
  a_bypass_start: assert property (interface_enable && async_buffer_bypass
    |-> rx_read_start && tx_read_start) else $error("bypass did not open buffers");
  a_rx_level: assert property (interface_enable && !async_buffer_bypass
    |-> rx_read_start == (rx_buffer_fill >= rx_buffer_midlevel)) else $error("rx start level");
  a_tx_level: assert property (interface_enable && !async_buffer_bypass
    |-> tx_read_start == (tx_buffer_fill >= tx_buffer_midlevel)) else $error("tx start level");
  // main scenarios reached
  c_drop: cover property (fast_link_drop);
  c_slverr: cover property (s_axi_bvalid && s_axi_bresp == phy_cfg_pkg::RESP_SLVERR);
  c_bypass: cover property (async_buffer_bypass && rx_read_start);
endmodule
bind phy_rgmii_fld_config_regs phy_cfg_monitor mon (.*);
`default_nettype wire

// File: testbench/mac_side_model.sv
// behavioural mac-side source of energy and buffer fill levels
`timescale 1ns/10ps
`default_nettype none
module mac_side_model (
  input wire logic aclk,
  input wire logic prompt,
  input wire logic [7:0] energy_set,
  input wire logic [1:0] rx_set,
  input wire logic [1:0] tx_set,
  output logic [7:0] energy_accumulator = 8'h00,
  output logic [1:0] rx_buffer_fill = 2'h0,
  output logic [1:0] tx_buffer_fill = 2'h0
);
  // a slow partner moves a fill one step a cycle, as a real buffer drains
  function automatic logic [1:0] step(input logic [1:0] cur, input logic [1:0] tgt);
    if (cur < tgt) return cur + 2'h1;
    if (cur > tgt) return cur - 2'h1;
    return cur;
  endfunction
  // levels change on the interface clock edge
  always_ff @(posedge aclk) begin
    energy_accumulator <= energy_set;
    rx_buffer_fill <= prompt ? rx_set : step(rx_buffer_fill, rx_set);
    tx_buffer_fill <= prompt ? tx_set : step(tx_buffer_fill, tx_set);
  end
endmodule
`default_nettype wire

// File: testbench/phy_rgmii_fld_config_regs_test.sv
// self-checking bench for the phy configuration register bank
`timescale 1ns/10ps
`default_nettype none
module phy_rgmii_fld_config_regs_test;
  logic aclk = 1'b0, aresetn = 1'b0, prompt = 1'b1;
  logic [9:0] s_axi_awaddr = '0, s_axi_araddr = '0;
  logic [31:0] s_axi_wdata = '0, s_axi_rdata;
  logic [3:0] s_axi_wstrb = 4'h3;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp, rx_set = 2'h0, tx_set = 2'h0;
  logic strap_fast_link_drop = 1'b0, strap_mirror = 1'b0, strap_interface_enable = 1'b0;
  logic package_small = 1'b0;
  logic [2:0] strap_rx_ctrl_mode = 3'h3;
  logic [7:0] energy_set = 8'h01, energy_accumulator;
  logic [1:0] rx_buffer_fill, tx_buffer_fill, rx_buffer_midlevel, tx_buffer_midlevel;
  logic energy_lost, fast_link_drop, internal_test_flag, mirror_enable, interface_enable;
  logic tx_clock_shift, rx_clock_shift, async_buffer_bypass, rx_read_start, tx_read_start;
  int err_total = 0;
  int checked = 0;
  // ----------------------------------------------------------------
  // design, far-side model and clock
  // ----------------------------------------------------------------
  phy_rgmii_fld_config_regs dut (.*);
  mac_side_model mac (.*);
  // 50 ns period
  initial begin
    forever #25 aclk = ~aclk;
  end
  // ----------------------------------------------------------------
  // compare, report and bus tasks
  // ----------------------------------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      err_total++;
      $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic chk_resp(input logic [1:0] got, input logic [1:0] exp);
    chk({30'h0, got}, {30'h0, exp});
  endtask
  task automatic summarize();
    $display("checked %0d mismatches %0d", checked, err_total);
    if (err_total == 0 && checked > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  task automatic give_up();
    err_total++;
    $display("MISMATCH t=%0t bus answer never came", $time);
    summarize();
  endtask
  // read at the falling edge: the value stands unchanged through the next rise
  task automatic axi_wr(input logic [7:0] idx, input logic [15:0] d, input logic [1:0] er);
    logic aw_ok, w_ok, b_ok;
    logic [1:0] got;
    b_ok = 1'b0;
    @(posedge aclk);
    s_axi_awaddr <= {idx, 2'b00};
    s_axi_wdata <= {16'h0000, d};
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'b111;
    for (int n = 0; !b_ok; n++) begin
      if (n > 40) give_up();
      @(negedge aclk);
      aw_ok = s_axi_awvalid & s_axi_awready;
      w_ok = s_axi_wvalid & s_axi_wready;
      b_ok = s_axi_bvalid;
      got = s_axi_bresp;
      @(posedge aclk);
      if (aw_ok) s_axi_awvalid <= 1'b0;
      if (w_ok) s_axi_wvalid <= 1'b0;
    end
    s_axi_bready <= 1'b0;
    chk_resp(got, er);
  endtask
  task automatic axi_rd(input logic [7:0] idx, input logic [15:0] ed, input logic [1:0] er);
    logic ar_ok, r_ok;
    logic [31:0] got;
    logic [1:0] rsp;
    r_ok = 1'b0;
    @(posedge aclk);
    s_axi_araddr <= {idx, 2'b00};
    {s_axi_arvalid, s_axi_rready} <= 2'b11;
    for (int n = 0; !r_ok; n++) begin
      if (n > 40) give_up();
      @(negedge aclk);
      ar_ok = s_axi_arvalid & s_axi_arready;
      r_ok = s_axi_rvalid;
      got = s_axi_rdata;
      rsp = s_axi_rresp;
      @(posedge aclk);
      if (ar_ok) s_axi_arvalid <= 1'b0;
    end
    s_axi_rready <= 1'b0;
    chk(got, {16'h0000, ed});
    chk_resp(rsp, er);
  endtask
  // straps stay put after release so the load edge sees them stable
  task automatic do_reset(input logic fl, input logic [2:0] md, input logic mi,
                          input logic ie, input logic sm);
    @(posedge aclk);
    aresetn <= 1'b0;
    strap_fast_link_drop <= fl;
    strap_rx_ctrl_mode <= md;
    strap_mirror <= mi;
    strap_interface_enable <= ie;
    package_small <= sm;
    repeat (5) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (2) @(posedge aclk);
    @(negedge aclk);
  endtask
  // four cycles cover the slow model's longest ramp
  task automatic set_link(input logic [7:0] e, input logic [1:0] rx, input logic [1:0] tx,
                          input logic p);
    @(posedge aclk);
    energy_set <= e;
    rx_set <= rx;
    tx_set <= tx;
    prompt <= p;
    repeat (4) @(posedge aclk);
    @(negedge aclk);
  endtask
  // ----------------------------------------------------------------
  // test sequence
  // ----------------------------------------------------------------
  initial begin
    logic [1:0] kk;
    for (int m = 0; m < 8; m++) begin
      do_reset(m[1], m[2:0], m[0], m[2], m[0]);
      chk(32'(internal_test_flag), 32'(!(m == 3 || m == 4)));
      chk(32'(mirror_enable), 32'(m[0]));
      chk(32'(interface_enable), 32'(m[0] | m[2]));
    end
    $display("test strap matrix done");
    do_reset(1'b1, 3'h3, 1'b1, 1'b0, 1'b0);
    chk(32'(energy_lost), 32'h0000_0001);
    axi_rd(8'h2e, 16'h0222, 2'h0);
    axi_rd(8'h31, 16'h0011, 2'h0);
    axi_rd(8'h32, 16'h0050, 2'h0);
    axi_rd(8'h33, 16'h0000, 2'h0);
    $display("test defaults done");
    axi_wr(8'h2e, 16'hffff, 2'h0);
    axi_rd(8'h2e, 16'h0777, 2'h0);
    axi_wr(8'h2e, 16'h0221, 2'h0);
    axi_rd(8'h2e, 16'h0221, 2'h0);
    set_link(8'h01, 2'h2, 2'h1, 1'b1);
    chk(32'(energy_lost), 32'h0000_0000);
    set_link(8'h00, 2'h2, 2'h1, 1'b1);
    chk(32'(energy_lost), 32'h0000_0001);
    chk(32'(fast_link_drop), 32'h0000_0000);
    axi_wr(8'h30, 16'h0001, 2'h0);
    @(negedge aclk);
    chk(32'(fast_link_drop), 32'h0000_0001);
    axi_rd(8'h30, 16'h0301, 2'h0);
    set_link(8'h40, 2'h2, 2'h1, 1'b1);
    chk(32'(fast_link_drop), 32'h0000_0000);
    axi_rd(8'h30, 16'h0201, 2'h0);
    $display("test energy floor done");
    for (int k = 0; k < 4; k++) begin
      kk = k[1:0];
      axi_wr(8'h32, {8'ha5, 1'b1, kk, kk, 1'b1, kk}, 2'h0);
      axi_rd(8'h32, {8'h00, 1'b1, kk, kk, 1'b0, kk}, 2'h0);
      @(negedge aclk);
      chk(32'(rx_buffer_midlevel), 32'(kk));
      chk(32'(tx_buffer_midlevel), 32'(kk));
      chk(32'(tx_clock_shift), 32'(kk[1]));
      chk(32'(rx_clock_shift), 32'(kk[0]));
      chk(32'(rx_read_start), 32'(k <= 2));
      chk(32'(tx_read_start), 32'(k <= 1));
    end
    $display("test interface control done");
    set_link(8'h40, 2'h0, 2'h0, 1'b0);
    axi_wr(8'h33, 16'hffff, 2'h0);
    axi_rd(8'h33, 16'h0010, 2'h0);
    @(negedge aclk);
    chk(32'({async_buffer_bypass, rx_read_start}), 32'h0000_0003);
    axi_wr(8'h32, 16'h0000, 2'h0);
    @(negedge aclk);
    chk(32'({interface_enable, tx_read_start}), 32'h0000_0000);
    axi_wr(8'h33, 16'h0000, 2'h0);
    axi_rd(8'h33, 16'h0000, 2'h0);
    $display("test bypass done");
    axi_wr(8'h31, 16'hffff, 2'h0);
    axi_rd(8'h31, 16'h0191, 2'h0);
    axi_wr(8'h31, 16'h0000, 2'h0);
    axi_rd(8'h31, 16'h0010, 2'h0);
    @(negedge aclk);
    chk(32'({internal_test_flag, mirror_enable}), 32'h0000_0000);
    axi_wr(8'h3f, 16'h1234, 2'h2);
    axi_rd(8'h3f, 16'h0000, 2'h2);
    $display("test cfg and unmapped done");
    do_reset(1'b0, 3'h4, 1'b0, 1'b0, 1'b1);
    axi_rd(8'h2e, 16'h0221, 2'h0);
    axi_rd(8'h31, 16'h0010, 2'h0);
    axi_rd(8'h32, 16'h00d0, 2'h0);
    $display("test second reset done");
    summarize();
  end
endmodule
`default_nettype wire
